// ### rtl/s8bc_codec.sv
// module: byte-wide 8b/10b encoder, serializer, deserializer and decoder
`timescale 1ns/1ps
`default_nettype none
module s8bc_codec
	import s8bc_pkg::*;
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RESET,
	// link reinit, power-state or diagnostic exit, one-cycle pulse
	input  wire logic       LINK_REINIT,
	// transmit byte stream from framing logic
	input  wire logic       TX_VALID,
	output logic            TX_READY,
	input  wire logic [7:0] TX_BYTE,
	input  wire logic       TX_IS_CTRL,
	output logic            TX_CTRL_ERR,
	// serial transmit toward the pin, first bit a
	output logic            TX_SERIAL,
	output logic            TX_SERIAL_VALID,
	// serial receive pin, one bit per clock
	input  wire logic       RX_SERIAL,
	// decoded receive stream
	output logic            RX_VALID,
	output logic      [7:0] RX_BYTE,
	output logic            RX_IS_CTRL,
	output logic            RX_CODE_ERR,
	output logic            RX_DISP_ERR
);

	////////////////////////////////////////////////////////////////////////
	// sub-block disparity and coding functions

	function automatic logic rd6_after(input logic [5:0] s,
	                                   input logic       rd);
		int n;
		n = $countones(s);
		if (n > 3 || s == S8BC_POS_6B) begin
			return S8BC_RD_POS;
		end else if (n < 3 || s == S8BC_NEG_6B) begin
			return S8BC_RD_NEG;
		end
		return rd;
	endfunction

	function automatic logic rd4_after(input logic [3:0] s,
	                                   input logic       rd);
		int n;
		n = $countones(s);
		if (n > 2 || s == S8BC_POS_4B) begin
			return S8BC_RD_POS;
		end else if (n < 2 || s == S8BC_NEG_4B) begin
			return S8BC_RD_NEG;
		end
		return rd;
	endfunction

	// returns {ending disparity, abcdei, fghj}
	function automatic logic [10:0] enc10(input logic [7:0] b,
	                                      input logic       k,
	                                      input logic       rd);
		logic [5:0] s6;
		logic [3:0] s4;
		logic       r6;
		logic       alt;
		s6 = k ? S8BC_K28_6B : S8BC_TBL6[b[4:0]];
		// complement unbalanced codes at positive start; 111000 becomes 000111
		if (rd && ($countones(s6) != 3 || s6 == S8BC_NEG_6B)) begin
			s6 = ~s6;
		end
		r6  = rd6_after(s6, rd);
		alt = !k && (b[7:5] == S8BC_Y7) &&
		      ((r6 && !s6[1] && !s6[0]) || (!r6 && s6[1] && s6[0]));
		s4  = alt ? S8BC_ALT4 : S8BC_TBL4[b[7:5]];
		if (r6 && ($countones(s4) != 2 || s4 == S8BC_NEG_4B)) begin
			s4 = ~s4;
		end
		return {rd4_after(s4, r6), s6, s4};
	endfunction

	// returns {found, is_ctrl, HGF, EDCBA}, both polarities searched
	function automatic logic [9:0] dec10(input logic [9:0] c);
		logic [5:0] t6;
		logic [3:0] t4;
		logic       f6;
		logic       f4;
		logic       k;
		logic [4:0] x;
		logic [2:0] y;
		f6 = 1'b0;
		f4 = 1'b0;
		k  = 1'b0;
		x  = '0;
		y  = '0;
		for (int i = 0; i < 32; i++) begin
			t6 = S8BC_TBL6[i];
			if (c[9:4] == t6 || (c[9:4] == ~t6 &&
			    ($countones(t6) != 3 || t6 == S8BC_NEG_6B))) begin
				f6 = 1'b1;
				x  = 5'(i);
			end
		end
		if (c[9:4] == S8BC_K28_6B || c[9:4] == ~S8BC_K28_6B) begin
			f6 = 1'b1;
			k  = 1'b1;
			x  = S8BC_K28_X;
		end
		for (int j = 0; j < 8; j++) begin
			t4 = S8BC_TBL4[j];
			if (c[3:0] == t4 || (c[3:0] == ~t4 &&
			    ($countones(t4) != 2 || t4 == S8BC_NEG_4B))) begin
				f4 = 1'b1;
				y  = 3'(j);
			end
		end
		if (c[3:0] == S8BC_ALT4 || c[3:0] == ~S8BC_ALT4) begin
			f4 = 1'b1;
			y  = S8BC_Y7;
		end
		return {f6 && f4, k, y, x};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// transmit buffer

	logic [8:0] fifo_data;
	logic       fifo_valid;
	logic       load;

	s8bc_fifo #(
		.WIDTH (S8BC_FIFO_WIDTH),
		.DEPTH (S8BC_FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.reset     (RESET),
		.in_valid  (TX_VALID),
		.in_ready  (TX_READY),
		.in_data   ({TX_IS_CTRL, TX_BYTE}),
		.out_valid (fifo_valid),
		.out_ready (load),
		.out_data  (fifo_data)
	);

	////////////////////////////////////////////////////////////////////////
	// encoder and serializer

	logic       tx_rd_reg;
	logic [9:0] tx_shift_reg;
	logic [3:0] tx_cnt_reg;
	logic       tx_busy_reg;
	logic       tx_ser_reg;
	logic       tx_cerr_reg;

	wire        tx_k      = fifo_data[8];
	wire  [7:0] tx_b      = fifo_data[7:0];
	wire        ctrl_ok   = (tx_b == S8BC_CTRL_COMMA) ||
	                        (tx_b == S8BC_CTRL_ALIGN);
	wire        tx_k_used = tx_k && ctrl_ok;
	wire [10:0] enc       = enc10(tx_b, tx_k_used, tx_rd_reg);
	wire  [9:0] enc_code  = enc[9:0];
	wire        last_bit  = (tx_cnt_reg == S8BC_LAST_BIT);

	assign load = fifo_valid && (!tx_busy_reg || last_bit);

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_rd_reg <= S8BC_RD_NEG;
		end else if (LINK_REINIT) begin
			tx_rd_reg <= S8BC_RD_NEG;
		end else if (load) begin
			tx_rd_reg <= enc[10];
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_shift_reg <= '0;
			tx_ser_reg   <= 1'b0;
		end else if (load) begin
			tx_shift_reg <= {enc_code[8:0], 1'b0};
			tx_ser_reg   <= enc_code[9];
		end else begin
			tx_shift_reg <= {tx_shift_reg[8:0], 1'b0};
			tx_ser_reg   <= tx_shift_reg[9];
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_cnt_reg  <= '0;
			tx_busy_reg <= 1'b0;
			tx_cerr_reg <= 1'b0;
		end else begin
			tx_cnt_reg  <= load ? '0 : tx_cnt_reg + 4'h1;
			tx_busy_reg <= load || (tx_busy_reg && !last_bit);
			tx_cerr_reg <= load && tx_k && !ctrl_ok;
		end
	end

	assign TX_SERIAL       = tx_ser_reg;
	assign TX_SERIAL_VALID = tx_busy_reg;
	assign TX_CTRL_ERR     = tx_cerr_reg;

	AST_LOAD_SERIAL: assert property (@(posedge CLK) disable iff (RESET)
		load |=> TX_SERIAL_VALID [*8])
		else $error("serial output stopped inside a character");
	AST_FIRST_BIT_A: assert property (@(posedge CLK) disable iff (RESET)
		load |=> TX_SERIAL == $past(enc_code[9]))
		else $error("first serial bit is not bit a");
	AST_NEUTRAL_4A: assert property (@(posedge CLK) disable iff (RESET)
		load && !tx_k && tx_b == 8'h4A |-> enc_code == 10'h155)
		else $error("byte 4A not coded as alternating pattern");
	AST_SPECIAL_6B: assert property (@(posedge CLK) disable iff (RESET)
		load && enc_code[9:4] == S8BC_POS_6B |-> tx_rd_reg)
		else $error("000111 emitted at negative disparity");
	AST_CHAR_BALANCE: assert property (@(posedge CLK) disable iff (RESET)
		load |-> $countones(enc_code) >= 4 && $countones(enc_code) <= 6)
		else $error("character disparity beyond two");
	AST_RD_FLIP: assert property (@(posedge CLK) disable iff (RESET)
		load && !LINK_REINIT && $countones(enc_code) != 5
		|=> tx_rd_reg != $past(tx_rd_reg))
		else $error("unbalanced character left disparity unchanged");
	AST_TX_RD_INIT: assert property (@(posedge CLK) disable iff (RESET)
		LINK_REINIT |=> tx_rd_reg == S8BC_RD_NEG)
		else $error("transmit disparity not negative after reinit");

	////////////////////////////////////////////////////////////////////////
	// receive synchroniser and deserializer

	logic       rx_meta_reg;
	logic       rx_sync_reg;
	logic [8:0] rx_shift_reg;
	logic [3:0] rx_cnt_reg;
	logic [9:0] rx_char_reg;
	logic       rx_stb_reg;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rx_meta_reg <= 1'b0;
			rx_sync_reg <= 1'b0;
		end else begin
			rx_meta_reg <= RX_SERIAL;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rx_shift_reg <= '0;
			rx_cnt_reg   <= '0;
			rx_char_reg  <= '0;
			rx_stb_reg   <= 1'b0;
		end else begin
			rx_shift_reg <= {rx_shift_reg[7:0], rx_sync_reg};
			rx_cnt_reg   <= (rx_cnt_reg == S8BC_LAST_BIT || LINK_REINIT) ?
			                '0 : rx_cnt_reg + 4'h1;
			rx_stb_reg   <= (rx_cnt_reg == S8BC_LAST_BIT) && !LINK_REINIT;
			if (rx_cnt_reg == S8BC_LAST_BIT) begin
				rx_char_reg <= {rx_shift_reg, rx_sync_reg};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoder and receive disparity

	logic       rx_rd_reg;
	logic       rx_known_reg;
	logic       rx_valid_reg;
	logic [7:0] rx_byte_reg;
	logic       rx_k_reg;
	logic       rx_cerr_reg;
	logic       rx_derr_reg;

	wire  [9:0] dec       = dec10(rx_char_reg);
	wire        dec_found = dec[9];
	wire        dec_k     = dec[8];
	wire  [7:0] dec_byte  = {dec[7:5], dec[4:0]};
	wire        dec_k_ok  = !dec_k || dec_byte == S8BC_CTRL_COMMA ||
	                        dec_byte == S8BC_CTRL_ALIGN;
	wire [10:0] exp_neg   = enc10(dec_byte, dec_k, S8BC_RD_NEG);
	wire [10:0] exp_pos   = enc10(dec_byte, dec_k, S8BC_RD_POS);
	wire        hit_neg   = exp_neg[9:0] == rx_char_reg;
	wire        hit_pos   = exp_pos[9:0] == rx_char_reg;
	wire        code_err  = !dec_found || !dec_k_ok ||
	                        (!hit_neg && !hit_pos);
	wire        hit_cur   = rx_rd_reg ? hit_pos : hit_neg;
	wire        disp_err  = !code_err && rx_known_reg && !hit_cur;
	// unknown start takes whichever polarity the character fits
	wire        rd_start  = rx_known_reg ? rx_rd_reg :
	                        (!hit_neg && hit_pos);
	wire        rd_mid    = rd6_after(rx_char_reg[9:4], rd_start);
	wire        rd_end    = rd4_after(rx_char_reg[3:0], rd_mid);

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rx_rd_reg    <= S8BC_RD_NEG;
			rx_known_reg <= 1'b0;
		end else if (LINK_REINIT) begin
			rx_known_reg <= 1'b0;
		end else if (rx_stb_reg) begin
			rx_rd_reg    <= rd_end;
			rx_known_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rx_valid_reg <= 1'b0;
			rx_byte_reg  <= '0;
			rx_k_reg     <= 1'b0;
			rx_cerr_reg  <= 1'b0;
			rx_derr_reg  <= 1'b0;
		end else begin
			rx_valid_reg <= rx_stb_reg;
			if (rx_stb_reg) begin
				rx_byte_reg <= dec_byte;
				rx_k_reg    <= dec_k;
				rx_cerr_reg <= code_err;
				rx_derr_reg <= disp_err;
			end
		end
	end

	assign RX_VALID    = rx_valid_reg;
	assign RX_BYTE     = rx_byte_reg;
	assign RX_IS_CTRL  = rx_k_reg;
	assign RX_CODE_ERR = rx_cerr_reg;
	assign RX_DISP_ERR = rx_derr_reg;

	AST_RX_GROUP: assert property (@(posedge CLK) disable iff (RESET)
		rx_stb_reg |=> RX_VALID ##1 !RX_VALID [*8])
		else $error("received characters not ten bits apart");
	AST_RX_CTRL: assert property (@(posedge CLK) disable iff (RESET)
		RX_VALID && RX_IS_CTRL && !RX_CODE_ERR
		|-> RX_BYTE == S8BC_CTRL_COMMA || RX_BYTE == S8BC_CTRL_ALIGN)
		else $error("unused control code accepted");
	AST_RX_FLAGS: assert property (@(posedge CLK) disable iff (RESET)
		RX_VALID && RX_CODE_ERR |-> !RX_DISP_ERR)
		else $error("violation and disparity error together");
	AST_RX_FIRST: assert property (@(posedge CLK) disable iff (RESET)
		rx_stb_reg && !rx_known_reg && !LINK_REINIT |=> !RX_DISP_ERR)
		else $error("disparity error on first character");

endmodule // s8bc_codec
`default_nettype wire

// ### rtl/s8bc_pkg.sv
// package: constants and coding tables for the serial 8b/10b codec
package s8bc_pkg;

	// character geometry
	localparam int          S8BC_CHAR_BITS = 10;
	localparam int          S8BC_BYTE_BITS = 8;
	localparam logic [3:0]  S8BC_LAST_BIT  = 4'h9;

	// transmit buffer shape
	localparam int          S8BC_FIFO_DEPTH = 16;
	localparam int          S8BC_FIFO_WIDTH = 9;

	// running disparity encoding and reset value
	localparam logic        S8BC_RD_NEG = 1'b0;
	localparam logic        S8BC_RD_POS = 1'b1;

	// the two control characters used on the link
	localparam logic [7:0]  S8BC_CTRL_COMMA = 8'hBC;
	localparam logic [7:0]  S8BC_CTRL_ALIGN = 8'h7C;

	// six-bit code of the control characters at negative disparity
	localparam logic [4:0]  S8BC_K28_X  = 5'h1C;
	localparam logic [5:0]  S8BC_K28_6B = 6'h0F;

	// special sub-block patterns
	localparam logic [5:0]  S8BC_POS_6B = 6'h07;
	localparam logic [5:0]  S8BC_NEG_6B = 6'h38;
	localparam logic [3:0]  S8BC_POS_4B = 4'h3;
	localparam logic [3:0]  S8BC_NEG_4B = 4'hC;

	// upper three bits all ones, and the alternate code for them
	localparam logic [2:0]  S8BC_Y7    = 3'h7;
	localparam logic [3:0]  S8BC_ALT4  = 4'h7;

	// six-bit codes abcdei for negative disparity, indexed by EDCBA
	localparam logic [5:0]  S8BC_TBL6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};

	// four-bit codes fghj for negative disparity, indexed by HGF
	localparam logic [3:0]  S8BC_TBL4 [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

endpackage

// ### rtl/s8bc_fifo.sv
// module: parameterised valid/ready FIFO in the transmit data path
`timescale 1ns/1ps
`default_nettype none
module s8bc_fifo
	import s8bc_pkg::*;
#(
	parameter int WIDTH = S8BC_FIFO_WIDTH,
	parameter int DEPTH = S8BC_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic             ready_reg;
	wire              push = in_valid && ready_reg;
	wire              pop  = out_ready && (count_reg != '0);

	assign in_ready   = ready_reg;
	assign out_valid  = (count_reg != '0);
	assign out_data   = mem[rd_ptr_reg];
	assign count_next = count_reg + CW'(push) - CW'(pop);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_next;
			ready_reg <= (count_next != FULL_CNT);
		end
	end
endmodule // s8bc_fifo
`default_nettype wire

// ### verification/s8bc_peer.sv
// partner model: peer link layer on the far side of the serial pins
`timescale 1ns/1ps
`default_nettype none
module s8bc_peer
	import s8bc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// serial stream from the codec
	input  wire logic       tx_serial,
	input  wire logic       tx_serial_valid,
	output logic      [9:0] got_code,
	output logic            got_strobe,
	// serial stream toward the codec
	output logic            rx_serial
);
	logic [9:0] mem [512];
	int         n_codes = 0;
	int         pos;
	logic [3:0] idx;
	logic [3:0] tcnt;
	logic [9:0] tsh;

	task automatic push(input logic [9:0] c);
		mem[n_codes] = c;
		n_codes++;
	endtask

	////////////////////////////////////////////////////////////////////////
	// one character every ten clocks, bit a first, no gaps
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			// two-bit lead covers the receiver's two-flop synchroniser
			idx <= 4'h2;
			pos <= -1;
		end else if (idx == S8BC_LAST_BIT) begin
			idx <= 4'h0;
			pos <= pos + 1;
		end else begin
			idx <= idx + 4'h1;
		end
	end
	// past the stream the line toggles every clock
	assign rx_serial = (pos >= 0 && pos < n_codes) ?
	                   mem[pos][4'h9 - idx] : idx[0];

	////////////////////////////////////////////////////////////////////////
	// gather sent bits into ten-bit characters
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			tcnt       <= 4'h0;
			tsh        <= 10'h000;
			got_code   <= 10'h000;
			got_strobe <= 1'b0;
		end else begin
			got_strobe <= 1'b0;
			if (tx_serial_valid) begin
				tsh <= {tsh[8:0], tx_serial};
				if (tcnt == S8BC_LAST_BIT) begin
					tcnt       <= 4'h0;
					got_code   <= {tsh[8:0], tx_serial};
					got_strobe <= 1'b1;
				end else begin
					tcnt <= tcnt + 4'h1;
				end
			end
		end
	end
endmodule // s8bc_peer
`default_nettype wire

// ### verification/s8bc_codec_bench.sv
// testbench: transmit and receive stream checks of the 8b/10b codec
`timescale 1ns/1ps
`default_nettype none
module s8bc_codec_bench
	import s8bc_pkg::*;
;
	typedef struct packed {
		logic [7:0] b;
		logic       k;
		logic       cerr;
		logic       derr;
	} s8bc_rx_type;

	logic        clk, reset, link_reinit;
	logic        tx_valid, tx_ready, tx_is_ctrl, tx_ctrl_err;
	logic [7:0]  tx_byte, rx_byte;
	logic        tx_serial, tx_serial_valid, rx_serial;
	logic        rx_valid, rx_is_ctrl, rx_code_err, rx_disp_err;
	logic [9:0]  got_code, code;
	logic        got_strobe, tx_rd, rx_rd, bad_rd, ready_low;
	int          err_count = 0;
	int          n_checks = 0;
	int          cerr_seen = 0;
	int          cerr_exp = 0;
	logic [9:0]  tx_exp [$];
	s8bc_rx_type rx_exp [$];
	s8bc_rx_type e;

	// rows: {control error expected, control, byte}
	localparam logic [9:0] ROWS [10] = '{
		10'h04A, 10'h1BC, 10'h0EB, 10'h0F1, 10'h007,
		10'h355, 10'h17C, 10'h000, 10'h0FF, 10'h063};

	s8bc_codec s8bc_codec_inst (
		.CLK(clk), .RESET(reset), .LINK_REINIT(link_reinit),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_BYTE(tx_byte),
		.TX_IS_CTRL(tx_is_ctrl), .TX_CTRL_ERR(tx_ctrl_err),
		.TX_SERIAL(tx_serial), .TX_SERIAL_VALID(tx_serial_valid),
		.RX_SERIAL(rx_serial), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
		.RX_IS_CTRL(rx_is_ctrl), .RX_CODE_ERR(rx_code_err),
		.RX_DISP_ERR(rx_disp_err));

	s8bc_peer s8bc_peer_inst (
		.clk(clk), .reset(reset), .tx_serial(tx_serial),
		.tx_serial_valid(tx_serial_valid), .got_code(got_code),
		.got_strobe(got_strobe), .rx_serial(rx_serial));

	////////////////////////////////////////////////////////////////////////
	// reference coder
	function automatic logic sub_rd(input logic [5:0] v, input int w,
		input logic rd);
		int o;
		o = $countones(v);
		if (2 * o > w || (w == 6 && v == S8BC_POS_6B) ||
			(w == 4 && v[3:0] == S8BC_POS_4B))
			return S8BC_RD_POS;
		if (2 * o < w || (w == 6 && v == S8BC_NEG_6B) ||
			(w == 4 && v[3:0] == S8BC_NEG_4B))
			return S8BC_RD_NEG;
		return rd;
	endfunction

	function automatic logic rd_after(input logic [9:0] c, input logic rd);
		return sub_rd({2'b00, c[3:0]}, 4, sub_rd(c[9:4], 6, rd));
	endfunction

	function automatic logic [9:0] enc(input logic [7:0] b, input logic k,
		inout logic rd);
		logic [5:0] s;
		logic [3:0] f;
		logic       r6;
		s = k ? S8BC_K28_6B : S8BC_TBL6[b[4:0]];
		if (rd == S8BC_RD_POS && ($countones(s) != 3 || s == S8BC_NEG_6B))
			s = ~s;
		r6 = sub_rd(s, 6, rd);
		f = S8BC_TBL4[b[7:5]];
		if (b[7:5] == S8BC_Y7 && ((r6 == S8BC_RD_POS && s[1:0] == 2'b00) ||
			(r6 == S8BC_RD_NEG && s[1:0] == 2'b11)))
			f = S8BC_ALT4;
		if (r6 == S8BC_RD_POS && ($countones(f) != 2 || f == S8BC_NEG_4B))
			f = ~f;
		rd = sub_rd({2'b00, f}, 4, r6);
		return {s, f};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reporting and drivers
	task automatic fail(input string m);
		err_count++;
		$display("FAIL %0t %s", $time, m);
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic rx_push(input logic [9:0] c, input logic [7:0] b,
		input logic k, input logic ce, input logic de);
		s8bc_peer_inst.push(c);
		rx_exp.push_back('{b, k, ce, de});
	endtask

	task automatic send(input logic [9:0] row);
		int n;
		tx_exp.push_back(enc(row[7:0], row[8] && !row[9], tx_rd));
		cerr_exp += int'(row[9]);
		tx_valid   <= 1'b1;
		tx_byte    <= row[7:0];
		tx_is_ctrl <= row[8];
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (tx_ready !== 1'b1)
				ready_low = 1'b1;
		end while (tx_ready !== 1'b1 && n < 200);
		if (n >= 200) begin
			fail("offer never taken");
			close_out();
		end
	endtask

	task automatic wait_empty(input int lim);
		int n;
		n = 0;
		while ((tx_exp.size() > 0 || rx_exp.size() > 0) && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			fail("stream stalled");
			close_out();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// monitors
	always @(posedge clk) begin
		if (tx_ctrl_err === 1'b1)
			cerr_seen++;
		if (got_strobe === 1'b1) begin
			n_checks++;
			if (tx_exp.size() == 0)
				fail("extra tx character");
			else if (got_code !== tx_exp.pop_front())
				fail("tx code mismatch");
		end
		if (rx_valid === 1'b1 && rx_exp.size() > 0) begin
			e = rx_exp.pop_front();
			n_checks++;
			if ({rx_code_err, rx_disp_err} !== {e.cerr, e.derr})
				fail("rx flags mismatch");
			if (!e.cerr && {rx_is_ctrl, rx_byte} !== {e.k, e.b})
				fail("rx byte mismatch");
		end
	end

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		reset       = 1'b1;
		link_reinit = 1'b0;
		tx_valid    = 1'b0;
		tx_byte     = 8'h00;
		tx_is_ctrl  = 1'b0;
		ready_low   = 1'b0;
		tx_rd       = S8BC_RD_NEG;
		rx_rd       = S8BC_RD_POS;
		rx_push(enc(8'hBC, 1'b1, rx_rd), 8'hBC, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 256; i++)
			rx_push(enc(i[7:0], 1'b0, rx_rd), i[7:0], 1'b0, 1'b0, 1'b0);
		rx_push(10'h000, 8'h00, 1'b0, 1'b1, 1'b0);
		rx_rd  = rd_after(10'h000, rx_rd);
		bad_rd = ~rx_rd;
		code   = enc(8'h00, 1'b0, bad_rd);
		rx_push(code, 8'h00, 1'b0, 1'b0, 1'b1);
		rx_rd = rd_after(code, rx_rd);
		rx_push(enc(8'h7C, 1'b1, rx_rd), 8'h7C, 1'b1, 1'b0, 1'b0);
		rx_push(enc(8'h4A, 1'b0, rx_rd), 8'h4A, 1'b0, 1'b0, 1'b0);
		repeat (4) @(posedge clk);
		n_checks++;
		if ({tx_ready, tx_serial_valid, rx_valid, tx_ctrl_err} !== 4'b1000)
			fail("outputs wrong in reset");
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		// rx framing runs from reset; drop the half-filled first frame
		repeat (9) @(posedge clk);
		link_reinit <= 1'b1;
		@(posedge clk);
		link_reinit <= 1'b0;
		// back-to-back offers overrun the 16-word buffer
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 10; i++)
				send(ROWS[i]);
		tx_valid <= 1'b0;
		wait_empty(5000);
		n_checks++;
		if (ready_low !== 1'b1)
			fail("buffer never refused");
		n_checks++;
		if (cerr_seen != cerr_exp)
			fail("control error count");
		// leave positive disparity behind, then reinitialise
		if (tx_rd == S8BC_RD_NEG)
			send(10'h1BC);
		tx_valid <= 1'b0;
		wait_empty(500);
		repeat (4) @(posedge clk);
		link_reinit <= 1'b1;
		@(posedge clk);
		link_reinit <= 1'b0;
		tx_rd = S8BC_RD_NEG;
		send(10'h000);
		tx_valid <= 1'b0;
		wait_empty(500);
		close_out();
	end
endmodule // s8bc_codec_bench
`default_nettype wire
